// file: design/atsio_top.sv
// auxiliary trigger input and sync/clock/gate output of a pattern generator
// assumes the pattern engine reports pattern/block starts and current indexes
//
// Behaviour
// RULE_01: rising aux edge starts a burst
// RULE_02: enable mode: aux low suppresses, high passes
// RULE_03: aux controls burst only in external burst
// RULE_04: combined channels: only master takes aux
// RULE_05: output picks clock, sync or burst gate
// RULE_06: wide option: ratios 2, 4, 8..511
// RULE_07: fixed option: max ratio per mode, 1 sub-rate
// RULE_08: single channel marker in 16-bit steps
// RULE_09: two channels: marker in 32-bit steps
// RULE_10: four channels: marker in 64-bit steps
// RULE_11: short patterns repeated to minimum length (no logic here does this; left to the pattern engine)
// RULE_12: alternate: marker at start of a or b
// RULE_13: mixed: marker chosen by block and row
// RULE_14: mixed alternate: also follows a/b choice
// RULE_15: sequence: marker tied to chosen block
// RULE_16: gate delay and width up to cycle-64
// RULE_17: burst cycle 1280..2^31 in 128 steps
// RULE_18: marker when bit count equals position
//
// The implementer's own choices: the address map and strobed register access.
`default_nettype none
module atsio_top (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_addr,      // register byte address
  input wire logic [31:0] i_wdata,    // register write data
  input wire logic i_wr,              // write strobe
  input wire logic i_rd,              // read strobe
  output logic [31:0] o_rdata,        // read data, cycle after i_rd
  input wire logic i_aux_in,          // auxiliary input level
  input wire logic i_pat_start,       // first word of a pattern or block
  input wire logic i_alt_b,           // current pattern is b
  input wire logic [7:0] i_blk_num,   // current block, 1-based
  input wire logic [7:0] i_row_num,   // current row, 1-based
  output logic o_aux_out,             // auxiliary output
  output logic o_data_en,             // burst data enable to engine
  output logic o_burst_start,         // one-cycle burst start pulse
  output logic o_aux_func             // aux level for alternate/sequence/error use
);
  // register state
  logic [14:0] ctrl_r, ctrl_nxt;      // control fields
  logic [8:0] div_r, div_nxt;         // clock division ratio
  logic [31:0] pos_r, pos_nxt;        // marker position, 1-based
  logic [15:0] sel_r, sel_nxt;        // row in [15:8], block in [7:0]
  logic [31:0] dly_r, dly_nxt;        // gate trigger delay, bits
  logic [31:0] wid_r, wid_nxt;        // gate pulse width, bits
  logic [31:0] cyc_r, cyc_nxt;        // burst cycle, bits
  logic [31:0] rdata_r, rdata_nxt;    // read data register
  // datapath state
  logic aux_d_r, aux_d_nxt;           // previous aux level
  logic [8:0] dcnt_r, dcnt_nxt;       // divider count
  logic [31:0] scnt_r, scnt_nxt;      // bits since marker start
  logic sarm_r, sarm_nxt;             // marker count running
  logic [31:0] bcnt_r, bcnt_nxt;      // bits into burst cycle
  logic brun_r, brun_nxt;             // burst cycle running
  logic out_r, out_nxt;               // aux output
  logic den_r, den_nxt;               // data enable
  logic bst_r, bst_nxt;               // burst start pulse
  logic func_r, func_nxt;             // aux passed to other uses
  // decoded fields
  atsio_pkg::atsio_osel_t osel;
  atsio_pkg::atsio_comb_t comb;
  atsio_pkg::atsio_src_t src;
  atsio_pkg::atsio_pmode_t pmode;
  atsio_pkg::atsio_rate_t rate;
  logic burst_on, aux_ok, aux_burst, aux_rise, div_ok, pos_ok, gate_ok, cyc_ok;
  logic tgt_hit, sync_hit, cyc_end, gate_win;
  logic [31:0] gran, step_mask, pos0;
  logic [8:0] div_max;

  // field decode and configuration checks
  always_comb begin
    osel = atsio_pkg::atsio_osel_t'(ctrl_r[atsio_pkg::CTRL_OSEL_LSB +: 2]);
    comb = atsio_pkg::atsio_comb_t'(ctrl_r[atsio_pkg::CTRL_COMB_LSB +: 2]);
    src = atsio_pkg::atsio_src_t'(ctrl_r[atsio_pkg::CTRL_SRC_LSB +: 2]);
    pmode = atsio_pkg::atsio_pmode_t'(ctrl_r[atsio_pkg::CTRL_PMODE_LSB +: 3]);
    rate = atsio_pkg::atsio_rate_t'(ctrl_r[atsio_pkg::CTRL_RATE_LSB +: 2]);
    burst_on = ctrl_r[atsio_pkg::CTRL_BURST];
    // slaves of a combination never see the pin
    aux_ok = (comb == atsio_pkg::COMB_ONE) || ctrl_r[atsio_pkg::CTRL_MASTER]; // RULE_04
    // aux is a burst control only for an external burst source
    aux_burst = aux_ok && burst_on && (src == atsio_pkg::SRC_TRIG || src == atsio_pkg::SRC_ENA); // RULE_03
    aux_rise = i_aux_in && !aux_d_r;
    // bits per clock and marker step follow the combination
    case (comb)
      atsio_pkg::COMB_TWO: gran = atsio_pkg::GRAN_TWO;   // RULE_09
      atsio_pkg::COMB_FOUR: gran = atsio_pkg::GRAN_FOUR; // RULE_10
      default: gran = atsio_pkg::GRAN_ONE;                // RULE_08
    endcase
    step_mask = gran - 32'h0000_0001;
    pos0 = pos_r - 32'h0000_0001;
    // position is 1 plus a whole number of steps
    pos_ok = (pos_r != 32'h0000_0000) && ((pos0 & step_mask) == 32'h0000_0000);
    // divider range by clock option and internal mode
    case (rate)
      atsio_pkg::RATE_HALF: div_max = atsio_pkg::DIV_MAX_HALF;     // RULE_07
      atsio_pkg::RATE_QUART: div_max = atsio_pkg::DIV_MAX_QUART;
      atsio_pkg::RATE_EIGHTH: div_max = atsio_pkg::DIV_MAX_EIGHTH;
      default: div_max = atsio_pkg::DIV_MAX_FULL;
    endcase
    if (ctrl_r[atsio_pkg::CTRL_WIDE]) begin
      div_ok = (div_r == 9'h002) || (div_r == 9'h004)
               || (div_r >= atsio_pkg::DIV_LIN_MIN && div_r <= atsio_pkg::DIV_MAX_FULL); // RULE_06
    end else begin
      div_ok = (div_r == 9'h002) || (div_r == 9'h004)
               || (div_r >= atsio_pkg::DIV_LIN_MIN && div_r <= div_max)
               || (div_r == 9'h001 && rate != atsio_pkg::RATE_FULL); // RULE_07
    end
    // burst cycle length limits
    cyc_ok = (cyc_r >= atsio_pkg::CYC_MIN) && (cyc_r <= atsio_pkg::CYC_MAX)
             && ((cyc_r & atsio_pkg::CYC_STEP_MASK) == 32'h0000_0000); // RULE_17
    // gate delay and width within cycle minus 64 bits
    gate_ok = cyc_ok && (dly_r <= cyc_r - atsio_pkg::GATE_MARGIN)
              && (wid_r <= cyc_r - atsio_pkg::GATE_MARGIN)
              && ((dly_r & atsio_pkg::GATE_STEP_MASK) == 32'h0000_0000)
              && ((wid_r & atsio_pkg::GATE_STEP_MASK) == 32'h0000_0000); // RULE_16
    // which pattern start arms the marker count
    case (pmode)
      atsio_pkg::PM_ALT: tgt_hit = (i_alt_b == ctrl_r[atsio_pkg::CTRL_ALT_B]); // RULE_12
      atsio_pkg::PM_MIXED: tgt_hit = (i_blk_num == sel_r[7:0]) && (i_row_num == sel_r[15:8]); // RULE_13
      atsio_pkg::PM_MIXALT: tgt_hit = (i_blk_num == sel_r[7:0]) && (i_row_num == sel_r[15:8])
                                      && (i_alt_b == ctrl_r[atsio_pkg::CTRL_ALT_B]); // RULE_14
      atsio_pkg::PM_SEQ: tgt_hit = (i_blk_num == sel_r[7:0]); // RULE_15
      default: tgt_hit = 1'b1;
    endcase
    // marker when the word holding the position goes out
    sync_hit = pos_ok && ((i_pat_start && tgt_hit && pos0 == 32'h0000_0000)
                          || (sarm_r && !i_pat_start && scnt_r == pos0)); // RULE_18
    cyc_end = (bcnt_r + gran) >= cyc_r;
    gate_win = gate_ok && brun_r && (bcnt_r >= dly_r) && (bcnt_r - dly_r < wid_r); // RULE_16
  end

  // register writes and reads
  always_comb begin
    ctrl_nxt = ctrl_r;
    div_nxt = div_r;
    pos_nxt = pos_r;
    sel_nxt = sel_r;
    dly_nxt = dly_r;
    wid_nxt = wid_r;
    cyc_nxt = cyc_r;
    rdata_nxt = 32'h0000_0000;
    if (i_wr) begin
      case (i_addr)
        atsio_pkg::ADDR_CTRL: ctrl_nxt = i_wdata[14:0];
        atsio_pkg::ADDR_DIV: div_nxt = i_wdata[8:0];
        atsio_pkg::ADDR_SYNC_POS: pos_nxt = i_wdata;
        atsio_pkg::ADDR_SYNC_SEL: sel_nxt = i_wdata[15:0];
        atsio_pkg::ADDR_GATE_DLY: dly_nxt = i_wdata;
        atsio_pkg::ADDR_GATE_WID: wid_nxt = i_wdata;
        atsio_pkg::ADDR_BURST_CYC: cyc_nxt = i_wdata;
        default: ; // unmapped and status writes are ignored
      endcase
    end
    if (i_rd) begin
      case (i_addr)
        atsio_pkg::ADDR_CTRL: rdata_nxt = {17'h0_0000, ctrl_r};
        atsio_pkg::ADDR_DIV: rdata_nxt = {23'h00_0000, div_r};
        atsio_pkg::ADDR_SYNC_POS: rdata_nxt = pos_r;
        atsio_pkg::ADDR_SYNC_SEL: rdata_nxt = {16'h0000, sel_r};
        atsio_pkg::ADDR_GATE_DLY: rdata_nxt = dly_r;
        atsio_pkg::ADDR_GATE_WID: rdata_nxt = wid_r;
        atsio_pkg::ADDR_BURST_CYC: rdata_nxt = cyc_r;
        atsio_pkg::ADDR_STATUS: rdata_nxt = {24'h00_0000, brun_r, den_r, aux_ok, i_aux_in,
                                             gate_ok, cyc_ok, pos_ok, div_ok};
        default: rdata_nxt = 32'h0000_0000; // unmapped reads as zero
      endcase
    end
  end

  // aux input handling, burst cycle and data enable
  always_comb begin
    aux_d_nxt = i_aux_in;
    bcnt_nxt = bcnt_r;
    brun_nxt = brun_r;
    bst_nxt = 1'b0;
    den_nxt = 1'b1;
    // aux goes to alternate, sequence or error use when not a burst control
    func_nxt = aux_ok && !aux_burst && i_aux_in; // RULE_03
    if (!burst_on || !cyc_ok) begin
      // continuous pattern, or cycle misprogrammed: no burst timing
      brun_nxt = 1'b0;
      bcnt_nxt = 32'h0000_0000;
      den_nxt = !burst_on;
    end else if (src == atsio_pkg::SRC_TRIG && aux_burst && aux_rise) begin
      // each rising edge starts a fresh burst
      brun_nxt = 1'b1; // RULE_01
      bcnt_nxt = 32'h0000_0000;
      bst_nxt = 1'b1;
      den_nxt = 1'b1;
    end else if (src == atsio_pkg::SRC_ENA) begin
      // enable level gates the data directly
      den_nxt = aux_burst && i_aux_in; // RULE_02
      brun_nxt = aux_burst && i_aux_in;
      bst_nxt = aux_burst && aux_rise;
      bcnt_nxt = (aux_burst && i_aux_in && !cyc_end && !aux_rise) ? bcnt_r + gran : 32'h0000_0000;
    end else if (src == atsio_pkg::SRC_INT && (!brun_r || cyc_end)) begin
      // internal source repeats the cycle forever
      brun_nxt = 1'b1;
      bcnt_nxt = 32'h0000_0000; // RULE_17
      bst_nxt = 1'b1;
    end else if (brun_r && cyc_end) begin
      // triggered burst ends after one cycle
      brun_nxt = 1'b0;
      bcnt_nxt = 32'h0000_0000;
      den_nxt = 1'b0;
    end else begin
      bcnt_nxt = brun_r ? bcnt_r + gran : bcnt_r;
      den_nxt = brun_r;
    end
  end

  // divider, marker counter and output selection
  always_comb begin
    dcnt_nxt = (dcnt_r + 9'h001 >= div_r) ? 9'h000 : dcnt_r + 9'h001;
    scnt_nxt = scnt_r;
    sarm_nxt = sarm_r;
    if (i_pat_start && tgt_hit) begin
      // count restarts at the first word of the chosen pattern
      scnt_nxt = gran; // RULE_18
      sarm_nxt = pos0 != 32'h0000_0000;
    end else if (sarm_r) begin
      scnt_nxt = scnt_r + gran;
      sarm_nxt = scnt_r != pos0;
    end
    case (osel)
      // high while twice the divider count does not exceed the ratio
      atsio_pkg::OSEL_CLK: out_nxt = div_ok && ({dcnt_nxt, 1'b0} < div_r + 9'h001); // RULE_05
      atsio_pkg::OSEL_SYNC: out_nxt = sync_hit; // RULE_05
      // gate only offered while burst sequencing is on
      atsio_pkg::OSEL_GATE: out_nxt = burst_on && gate_win; // RULE_05
      default: out_nxt = 1'b0;
    endcase
  end

  // state registers
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ctrl_r <= atsio_pkg::CTRL_RST;
      div_r <= atsio_pkg::DIV_RST;
      pos_r <= atsio_pkg::POS_RST;
      sel_r <= 16'h0101;
      dly_r <= 32'h0000_0000;
      wid_r <= 32'h0000_0000;
      cyc_r <= atsio_pkg::CYC_RST;
      rdata_r <= 32'h0000_0000;
      aux_d_r <= 1'b0;
      dcnt_r <= 9'h000;
      scnt_r <= 32'h0000_0000;
      sarm_r <= 1'b0;
      bcnt_r <= 32'h0000_0000;
      brun_r <= 1'b0;
      out_r <= 1'b0;
      den_r <= 1'b0;
      bst_r <= 1'b0;
      func_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      div_r <= div_nxt;
      pos_r <= pos_nxt;
      sel_r <= sel_nxt;
      dly_r <= dly_nxt;
      wid_r <= wid_nxt;
      cyc_r <= cyc_nxt;
      rdata_r <= rdata_nxt;
      aux_d_r <= aux_d_nxt;
      dcnt_r <= dcnt_nxt;
      scnt_r <= scnt_nxt;
      sarm_r <= sarm_nxt;
      bcnt_r <= bcnt_nxt;
      brun_r <= brun_nxt;
      out_r <= out_nxt;
      den_r <= den_nxt;
      bst_r <= bst_nxt;
      func_r <= func_nxt;
    end
  end

  // outputs straight from flops
  assign o_rdata = rdata_r;
  assign o_aux_out = out_r;
  assign o_data_en = den_r;
  assign o_burst_start = bst_r;
  assign o_aux_func = func_r;

  // checks
  property p_trig_start;
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_wr == 1'b0 && burst_on && cyc_ok && src == atsio_pkg::SRC_TRIG && aux_burst && aux_rise)
      |=> (o_burst_start && o_data_en) ##1 (!o_burst_start);
  endproperty
  a_trig_start: assert property (p_trig_start) else $error("trigger edge did not start burst"); // RULE_01
  property p_enable;
    @(posedge i_clk) disable iff (!i_rst_n)
    (burst_on && cyc_ok && src == atsio_pkg::SRC_ENA && aux_burst) |=> (o_data_en == $past(i_aux_in));
  endproperty
  a_enable: assert property (p_enable) else $error("data enable does not follow aux level"); // RULE_02
  property p_other_use;
    @(posedge i_clk) disable iff (!i_rst_n)
    aux_burst |=> !o_aux_func;
  endproperty
  a_other_use: assert property (p_other_use) else $error("burst control aux leaked to other use"); // RULE_03
  property p_slave;
    @(posedge i_clk) disable iff (!i_rst_n)
    (comb != atsio_pkg::COMB_ONE && !ctrl_r[atsio_pkg::CTRL_MASTER]) |=> !o_aux_func;
  endproperty
  a_slave: assert property (p_slave) else $error("slave module reacted to aux"); // RULE_04
  property p_gate_burst;
    @(posedge i_clk) disable iff (!i_rst_n)
    (osel == atsio_pkg::OSEL_GATE && !burst_on) |=> !o_aux_out;
  endproperty
  a_gate_burst: assert property (p_gate_burst) else $error("gate output without burst"); // RULE_05
  property p_div_bad;
    @(posedge i_clk) disable iff (!i_rst_n)
    (osel == atsio_pkg::OSEL_CLK && !div_ok) |=> !o_aux_out;
  endproperty
  a_div_bad: assert property (p_div_bad) else $error("clock out on illegal ratio"); // RULE_06
  property p_sync_hit;
    @(posedge i_clk) disable iff (!i_rst_n)
    (osel == atsio_pkg::OSEL_SYNC && sarm_r && !i_pat_start && pos_ok && scnt_r == pos0) |=> o_aux_out;
  endproperty
  a_sync_hit: assert property (p_sync_hit) else $error("sync marker missed its position"); // RULE_18
  property p_gate_open;
    @(posedge i_clk) disable iff (!i_rst_n)
    (osel == atsio_pkg::OSEL_GATE && burst_on && gate_ok && brun_r && bcnt_r == dly_r && wid_r != 32'h0)
      |=> o_aux_out;
  endproperty
  a_gate_open: assert property (p_gate_open) else $error("gate did not open at delay"); // RULE_16
  property p_cycle_wrap;
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_wr == 1'b0 && burst_on && cyc_ok && src == atsio_pkg::SRC_INT && brun_r && cyc_end)
      |=> (bcnt_r == 32'h0 && o_burst_start);
  endproperty
  a_cycle_wrap: assert property (p_cycle_wrap) else $error("burst cycle did not wrap"); // RULE_17
endmodule : atsio_top
`default_nettype wire

// file: design/atsio_pkg.sv
// constants for the auxiliary trigger input and sync output block
// assumes one bit-rate word per clock; register offsets, control field positions and limits live here
`default_nettype none
package atsio_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DIV = 8'h04;
  localparam logic [7:0] ADDR_SYNC_POS = 8'h08;
  localparam logic [7:0] ADDR_SYNC_SEL = 8'h0c;
  localparam logic [7:0] ADDR_GATE_DLY = 8'h10;
  localparam logic [7:0] ADDR_GATE_WID = 8'h14;
  localparam logic [7:0] ADDR_BURST_CYC = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1c;
  // control register field positions
  localparam int CTRL_OSEL_LSB = 0;   // 2 bits output source
  localparam int CTRL_COMB_LSB = 2;   // 2 bits channel combination
  localparam int CTRL_MASTER = 4;     // this module is master
  localparam int CTRL_SRC_LSB = 5;    // 2 bits burst source
  localparam int CTRL_BURST = 7;      // burst sequencing on
  localparam int CTRL_PMODE_LSB = 8;  // 3 bits pattern mode
  localparam int CTRL_RATE_LSB = 11;  // 2 bits internal clock mode
  localparam int CTRL_WIDE = 13;      // wide-range clock option
  localparam int CTRL_ALT_B = 14;     // alternate marker on pattern b
  localparam int CTRL_W = 15;
  // values after reset
  localparam logic [14:0] CTRL_RST = 15'h0000;
  localparam logic [8:0] DIV_RST = 9'h002;
  localparam logic [31:0] POS_RST = 32'h0000_0001;
  localparam logic [31:0] CYC_RST = 32'h0000_0500;
  // documented limits, in bits
  localparam logic [31:0] CYC_MIN = 32'h0000_0500;   // 1 280
  localparam logic [31:0] CYC_MAX = 32'h8000_0000;   // 2 147 483 648
  localparam logic [31:0] CYC_STEP_MASK = 32'h0000_007f;  // 128-bit steps
  localparam logic [31:0] GATE_MARGIN = 32'h0000_0040;    // 64 bits
  localparam logic [31:0] GATE_STEP_MASK = 32'h0000_000f; // 16-bit steps
  localparam logic [8:0] DIV_MAX_FULL = 9'h1ff;
  localparam logic [8:0] DIV_MAX_HALF = 9'h0ff;
  localparam logic [8:0] DIV_MAX_QUART = 9'h07f;
  localparam logic [8:0] DIV_MAX_EIGHTH = 9'h03f;
  localparam logic [8:0] DIV_LIN_MIN = 9'h008;
  // bits carried per clock for each combination
  localparam logic [31:0] GRAN_ONE = 32'h0000_0010;
  localparam logic [31:0] GRAN_TWO = 32'h0000_0020;
  localparam logic [31:0] GRAN_FOUR = 32'h0000_0040;
  // modes
  typedef enum logic [1:0] {OSEL_CLK, OSEL_SYNC, OSEL_GATE, OSEL_RSV} atsio_osel_t;
  typedef enum logic [1:0] {COMB_ONE, COMB_TWO, COMB_FOUR, COMB_RSV} atsio_comb_t;
  typedef enum logic [1:0] {SRC_INT, SRC_TRIG, SRC_ENA, SRC_RSV} atsio_src_t;
  typedef enum logic [2:0] {PM_PRBS, PM_ALT, PM_MIXED, PM_MIXALT, PM_SEQ} atsio_pmode_t;
  typedef enum logic [1:0] {RATE_FULL, RATE_HALF, RATE_QUART, RATE_EIGHTH} atsio_rate_t;
endpackage : atsio_pkg
`default_nettype wire

// file: tb/atsio_aux_partner.sv
// far-side equipment model that drives the auxiliary input line
// assumes the bench asks for a level; the line follows one or two clocks later
`default_nettype none
module atsio_aux_partner (
  input wire logic i_clk,
  input wire logic i_level,  // level the bench wants on the line
  input wire logic i_slow,   // answer one clock later than usual
  output logic o_aux         // auxiliary line into the device
);
  timeunit 1ns;
  timeprecision 1ns;
  logic lvl_r;  // first delay stage
  // line starts low so the device never sees an unknown level
  initial begin
    lvl_r = 1'b0;
    o_aux = 1'b0;
  end
  // the line changes only right after a rising edge, like real equipment
  always @(posedge i_clk) begin
    lvl_r <= i_level;
    o_aux <= i_slow ? lvl_r : i_level;
  end
endmodule : atsio_aux_partner
`default_nettype wire

// file: tb/atsio_top_tb.sv
// self-checking bench for the aux trigger input and sync output block
// assumes the device map of atsio_pkg and the aux partner model
`default_nettype none
module atsio_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, wr, rd, lvl, slow, pat, alt_b;
  logic [7:0] addr, blk, row;
  logic [31:0] wdata, rdata, rv;
  logic aux, aux_out, data_en, bstart, aux_func;
  int err_count, n_compared, first, fs, fg, ns, nd, ng;
  // reset values and one unmapped place: address, expected value
  localparam int RST_T [9][2] = '{'{8'h04, 2}, '{8'h08, 1}, '{8'h0c, 32'h101}, '{8'h10, 0},
    '{8'h14, 0}, '{8'h18, 32'h500}, '{8'h00, 0}, '{8'h20, 0}, '{8'h1c, 32'h6f}};
  // divider cases: control, ratio, high cycles per period
  localparam int DIV_T [12][3] = '{'{32'h2000, 4, 3}, '{32'h2000, 9, 5}, '{32'h2000, 5, 0},
    '{32'h2000, 511, 256}, '{0, 511, 256}, '{0, 1, 0}, '{32'h0800, 1, 1}, '{32'h0800, 255, 128},
    '{32'h0800, 256, 0}, '{32'h1800, 63, 32}, '{32'h1800, 64, 0}, '{32'h1000, 127, 64}};
  // marker cases: control, position, row in [15:8] and block in [7:0], pattern b, cycles to pulse (0 none)
  localparam int SYN_T [15][5] = '{'{1, 1, 1, 0, 1}, '{1, 33, 1, 0, 3}, '{1, 18, 1, 0, 0},
    '{5, 33, 1, 0, 2}, '{9, 65, 1, 0, 2}, '{32'h101, 17, 1, 0, 2}, '{32'h4101, 17, 1, 0, 0},
    '{32'h4101, 17, 1, 1, 2}, '{32'h201, 1, 32'h102, 0, 0}, '{32'h201, 1, 32'h103, 0, 1},
    '{32'h301, 1, 32'h103, 1, 0}, '{32'h301, 1, 32'h103, 0, 1}, '{32'h401, 17, 2, 0, 0},
    '{32'h401, 17, 3, 0, 2}, '{32'h201, 1, 32'h203, 0, 0}};
  // burst cases: control, cycle, starts, enable cycles, gate cycles, gate offset
  localparam int BUR_T [7][6] = '{'{32'ha2, 32'h500, 1, 80, 4, 3}, '{32'ha6, 32'h500, 0, 0, 0, 0},
    '{32'hb6, 32'h500, 1, 40, 2, 2}, '{32'ha2, 32'h3e8, 0, 0, 0, 0},
    '{32'ha2, 32'h580, 1, 88, 4, 3}, '{32'h22, 32'h500, 0, 110, 0, 0},
    '{32'h82, 32'h500, 1, 110, 4, 3}};
  // level cases: control, aux level, data enable, aux copy
  localparam int LVL_T [5][4] = '{'{32'hc2, 1, 1, 0}, '{32'hc2, 0, 0, 0}, '{0, 1, 1, 1},
    '{4, 1, 1, 0}, '{32'h14, 1, 1, 1}};

  atsio_top u_dut (.i_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_aux_in(aux), .i_pat_start(pat), .i_alt_b(alt_b),
    .i_blk_num(blk), .i_row_num(row), .o_aux_out(aux_out), .o_data_en(data_en),
    .o_burst_start(bstart), .o_aux_func(aux_func));
  atsio_aux_partner u_partner (.i_clk(clk), .i_level(lvl), .i_slow(slow), .o_aux(aux));

  // free-running bit-word clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // compare one value and count it
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one-cycle write strobe
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) begin
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
    end
    @(posedge clk) wr <= 1'b0;
  endtask : wr_reg
  // one-cycle read strobe, data taken in the following cycle only
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk) begin
      addr <= a;
      rd <= 1'b1;
    end
    @(posedge clk) rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  // verdict and end of run
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test
  // hang guard, well above the expected run length
  initial begin
    #(40 * 40000);
    err_count++;
    stop_test();
  end
  // main sequence
  initial begin
    err_count = 0;
    n_compared = 0;
    {rst_n, wr, rd, lvl, slow, pat, alt_b} = '0;
    addr = 8'h00;
    wdata = 32'h0;
    blk = 8'h01;
    row = 8'h01;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      rd_reg(8'(RST_T[i][0]), rv);
      chk(rv, 32'(RST_T[i][1]));
    end
    // read data stand one cycle only, then fall back to zero
    @(posedge clk);
    #1 chk(rdata, 32'h0);
    chk(32'(data_en), 32'h1);
    // divided clock: count high cycles over one full period after settling
    for (int i = 0; i < 12; i++) begin
      wr_reg(atsio_pkg::ADDR_CTRL, 32'(DIV_T[i][0]));
      wr_reg(atsio_pkg::ADDR_DIV, 32'(DIV_T[i][1]));
      repeat (520) @(posedge clk);
      nd = 0;
      for (int k = 0; k < DIV_T[i][1]; k++) begin
        #1 nd += (aux_out === 1'b1);
        @(posedge clk);
      end
      chk(32'(nd), 32'(DIV_T[i][2]));
    end
    // sync marker: cycles from the pattern start word to the pulse
    wr_reg(atsio_pkg::ADDR_SYNC_SEL, 32'h0000_0103);
    for (int i = 0; i < 15; i++) begin
      wr_reg(atsio_pkg::ADDR_CTRL, 32'(SYN_T[i][0]));
      wr_reg(atsio_pkg::ADDR_SYNC_POS, 32'(SYN_T[i][1]));
      @(posedge clk) begin
        pat <= 1'b1;
        blk <= 8'(SYN_T[i][2]);
        row <= 8'(SYN_T[i][2] >> 8);
        alt_b <= 1'(SYN_T[i][3]);
      end
      @(posedge clk) pat <= 1'b0;
      first = 0;
      for (int k = 1; k <= 20; k++) begin
        #1 if (aux_out === 1'b1 && first == 0) first = k;
        @(posedge clk);
      end
      chk(32'(first), 32'(SYN_T[i][4]));
    end
    // gate bursts: triggered, internal and burst off; cycle lengths are 128-bit multiples except the 1000-bit case
    wr_reg(atsio_pkg::ADDR_GATE_DLY, 32'h20);
    wr_reg(atsio_pkg::ADDR_GATE_WID, 32'h40);
    for (int i = 0; i < 7; i++) begin
      wr_reg(atsio_pkg::ADDR_CTRL, 32'(BUR_T[i][0]));
      wr_reg(atsio_pkg::ADDR_BURST_CYC, 32'(BUR_T[i][1]));
      slow <= (i == 4);
      repeat (100) @(posedge clk);
      lvl <= 1'b1;
      {ns, nd, ng, fs, fg} = '0;
      for (int k = 1; k <= 110; k++) begin
        @(posedge clk);
        #1;
        if (bstart === 1'b1) begin
          ns++;
          if (fs == 0) fs = k;
        end
        nd += (data_en === 1'b1);
        if (aux_out === 1'b1) begin
          ng++;
          if (fg == 0) fg = k;
        end
      end
      lvl <= 1'b0;
      chk(32'(ns), 32'(BUR_T[i][2]));
      chk(32'(nd), 32'(BUR_T[i][3]));
      chk(32'(ng), 32'(BUR_T[i][4]));
      chk(32'(fg - fs), 32'(BUR_T[i][5]));
    end
    // enable-level burst and plain aux copy
    slow <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      wr_reg(atsio_pkg::ADDR_CTRL, 32'(LVL_T[i][0]));
      lvl <= 1'(LVL_T[i][1]);
      repeat (6) @(posedge clk);
      #1;
      chk(32'(data_en), 32'(LVL_T[i][2]));
      chk(32'(aux_func), 32'(LVL_T[i][3]));
    end
    stop_test();
  end
endmodule : atsio_top_tb
`default_nettype wire
